/* File: common/tcsf_pkg.sv */
// Constants shared by the thermocouple status flag block
package tcsf_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] TCSF_ADDR_STATUS = 8'h00;
	localparam logic [7:0] TCSF_ADDR_IRQ_STATUS = 8'h04;
	localparam logic [7:0] TCSF_ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] TCSF_ADDR_HOT = 8'h0C;
	localparam logic [7:0] TCSF_ADDR_DIFF = 8'h10;
	localparam logic [7:0] TCSF_ADDR_COLD = 8'h14;
	localparam logic [7:0] TCSF_ADDR_ALERT_SRC = 8'h18;
	localparam logic [7:0] TCSF_ADDR_LIMIT0 = 8'h1C;
	localparam logic [7:0] TCSF_LIMIT_STRIDE = 8'h04;
	// Status bit positions
	localparam int TCSF_BIT_BURST = 7;
	localparam int TCSF_BIT_CONV = 6;
	localparam int TCSF_BIT_SHORT = 5;
	localparam int TCSF_BIT_RANGE = 4;
	localparam int TCSF_NUM_ALERTS = 4;
	// Widths
	localparam int TCSF_FLAG_W = 8;
	localparam int TCSF_TEMP_W = 16;
	localparam int TCSF_DATA_W = 32;
	localparam int TCSF_AOFS_W = 8;
	// Reset values
	localparam logic [7:0] TCSF_FLAGS_RST = 8'h00;
	localparam logic [15:0] TCSF_TEMP_RST = 16'h0000;
	localparam logic [3:0] TCSF_SRC_RST = 4'h0;
	localparam logic [31:0] TCSF_DATA_RST = 32'h00000000;
	// Bus encodings
	localparam logic [1:0] TCSF_HRESP_OKAY = 2'h0;
endpackage

/* File: core/tcsf_status.sv */
// Thermocouple converter status flags, result hold logic and bus slave
`timescale 1ns/1ns
module tcsf_status
	import tcsf_pkg::*;
#(
	parameter bit FAULT_DETECT = 1'b1,
	parameter int NUM_ALERTS = TCSF_NUM_ALERTS
) (
	// Clock and synchronous reset
	input wire logic CLOCK,
	input wire logic RST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic [1:0] HRESP,
	// Conversion engine results
	input wire logic CONV_DONE,
	input wire logic BURST_DONE,
	input wire logic [15:0] CONV_HOT,
	input wire logic [15:0] CONV_DIFF,
	input wire logic [15:0] CONV_COLD,
	input wire logic EMF_OVER_RANGE,
	input wire logic SUM_OVER_RANGE,
	// Fault sense front end
	input wire logic SHORT_DETECT,
	input wire logic OPEN_DETECT,
	// Interrupt and alert outputs
	output logic IRQ,
	output logic [3:0] ALERT_STATE
);

	// Bus request decode
	logic addr_take; // Valid transfer seen in address phase
	logic rd_take; // Read address phase
	logic [7:0] addr_ofs; // Offset of the address phase
	logic wr_q_reg; // Write pending in data phase
	logic [7:0] addr_q_reg; // Offset held for the data phase
	logic [31:0] rdata_reg; // Registered read data
	logic [31:0] rd_value; // Read mux output

	// Flag and result state
	logic burst_reg;
	logic burst_next;
	logic conv_reg;
	logic conv_next;
	logic range_reg; // Range fault of the latest conversion
	logic [15:0] hot_reg;
	logic [15:0] diff_reg;
	logic [15:0] cold_reg;
	logic [3:0] alert_src_reg; // Per alert: 1 picks cold junction
	logic [15:0] limit_reg [NUM_ALERTS];
	logic [NUM_ALERTS-1:0] alert_bits;
	logic short_bit;
	logic range_bit;
	logic [7:0] status_value; // Flag byte as software sees it

	// Interrupt state
	logic [7:0] irq_reg;
	logic [7:0] irq_next;
	logic [7:0] mask_reg;
	logic [5:0] prev_reg; // Level flags last cycle, for rise events
	logic [7:0] event_vec;
	logic irq_rd_clr;

	// Data phase write strobes
	logic wr_status;
	logic wr_mask;
	logic wr_src;

	// Address phase decode
	assign addr_take = HSEL && HREADY && HTRANS[1];
	assign rd_take = addr_take && !HWRITE;
	assign addr_ofs = HADDR[TCSF_AOFS_W-1:0];
	assign wr_status = wr_q_reg && (addr_q_reg == TCSF_ADDR_STATUS);
	assign wr_mask = wr_q_reg && (addr_q_reg == TCSF_ADDR_IRQ_MASK);
	assign wr_src = wr_q_reg && (addr_q_reg == TCSF_ADDR_ALERT_SRC);
	// Read clear acts at the address phase, same edge as data capture
	assign irq_rd_clr = rd_take && (addr_ofs == TCSF_ADDR_IRQ_STATUS);

	// Slave never stalls and never errors
	assign HREADYOUT = 1'b1;
	assign HRESP = TCSF_HRESP_OKAY;
	assign HRDATA = rdata_reg;

	// Address phase capture for writes
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			wr_q_reg <= 1'b0;
			addr_q_reg <= TCSF_ADDR_STATUS;
		end else begin
			wr_q_reg <= addr_take && HWRITE;
			addr_q_reg <= addr_ofs;
		end
	end

	// Read mux, unmapped offsets read zero
	always_comb begin
		rd_value = TCSF_DATA_RST;
		case (addr_ofs)
			TCSF_ADDR_STATUS: rd_value[7:0] = status_value;
			TCSF_ADDR_IRQ_STATUS: rd_value[7:0] = irq_reg;
			TCSF_ADDR_IRQ_MASK: rd_value[7:0] = mask_reg;
			TCSF_ADDR_HOT: rd_value[15:0] = hot_reg;
			TCSF_ADDR_DIFF: rd_value[15:0] = diff_reg;
			TCSF_ADDR_COLD: rd_value[15:0] = cold_reg;
			TCSF_ADDR_ALERT_SRC: rd_value[3:0] = alert_src_reg;
			default: rd_value = TCSF_DATA_RST;
		endcase
		// Alert limit words follow each other
		for (int k = 0; k < NUM_ALERTS; k++) begin
			if (addr_ofs == TCSF_ADDR_LIMIT0 + TCSF_LIMIT_STRIDE * 8'(k))
				rd_value[15:0] = limit_reg[k];
		end
	end

	// Read data register, held through the data phase
	always_ff @(posedge CLOCK) begin
		if (RST)
			rdata_reg <= TCSF_DATA_RST;
		else if (rd_take)
			rdata_reg <= rd_value;
	end

	// Completion flags: a new event beats a clear in the same cycle
	assign burst_next = BURST_DONE
		|| (burst_reg && !(wr_status && !HWDATA[TCSF_BIT_BURST]));
	assign conv_next = CONV_DONE
		|| (conv_reg && !(wr_status && !HWDATA[TCSF_BIT_CONV]));

	// Flag registers; read-only bits ignore writes
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			burst_reg <= 1'b0;
			conv_reg <= 1'b0;
		end else begin
			burst_reg <= burst_next;
			conv_reg <= conv_next;
		end
	end

	// Result registers, hold pattern depends on which range failed
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			hot_reg <= TCSF_TEMP_RST;
			diff_reg <= TCSF_TEMP_RST;
			cold_reg <= TCSF_TEMP_RST;
			range_reg <= 1'b0;
		end else if (CONV_DONE) begin
			// Cold junction always refreshes
			cold_reg <= CONV_COLD;
			// EMF overrange freezes hot and difference
			if (!EMF_OVER_RANGE)
				diff_reg <= CONV_DIFF;
			// Sum overrange freezes only hot
			if (!EMF_OVER_RANGE && !SUM_OVER_RANGE)
				hot_reg <= CONV_HOT;
			range_reg <= EMF_OVER_RANGE || SUM_OVER_RANGE;
		end
	end

	// Short bit and the open input term exist only on the detecting variant
	assign short_bit = FAULT_DETECT && SHORT_DETECT;
	// Open input drives EMF past range, so it shares the range bit
	assign range_bit = range_reg || (FAULT_DETECT && OPEN_DETECT);

	// Alert comparators, one per limit
	genvar gi;
	generate
		for (gi = 0; gi < NUM_ALERTS; gi++) begin : g_alert
			logic [15:0] alert_temp; // Selected junction temperature
			logic lim_wr;
			assign alert_temp = alert_src_reg[gi] ? cold_reg : hot_reg;
			// Strictly above the limit; equal reads zero
			assign alert_bits[gi] =
				$signed(alert_temp) > $signed(limit_reg[gi]);
			assign lim_wr = wr_q_reg && (addr_q_reg ==
				TCSF_ADDR_LIMIT0 + TCSF_LIMIT_STRIDE * 8'(gi));
			// Limit register
			always_ff @(posedge CLOCK) begin
				if (RST)
					limit_reg[gi] <= TCSF_TEMP_RST;
				else if (lim_wr)
					limit_reg[gi] <= HWDATA[TCSF_TEMP_W-1:0];
			end
		end
	endgenerate

	assign status_value = {burst_reg, conv_reg, short_bit, range_bit,
		alert_bits};
	assign ALERT_STATE = alert_bits;

	// Interrupt events: completions as pulses, levels on their rise
	assign event_vec = {BURST_DONE, CONV_DONE,
		status_value[5:0] & ~prev_reg};
	// Event wins over a read clear in the same cycle
	assign irq_next = event_vec | (irq_reg & ~{TCSF_FLAG_W{irq_rd_clr}});
	assign IRQ = |(irq_reg & mask_reg);

	// Interrupt, mask and source select registers
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			irq_reg <= TCSF_FLAGS_RST;
			mask_reg <= TCSF_FLAGS_RST;
			prev_reg <= TCSF_FLAGS_RST[5:0];
			alert_src_reg <= TCSF_SRC_RST;
		end else begin
			irq_reg <= irq_next;
			prev_reg <= status_value[5:0];
			if (wr_mask)
				mask_reg <= HWDATA[TCSF_FLAG_W-1:0];
			if (wr_src)
				alert_src_reg <= HWDATA[3:0];
		end
	end

	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence seq_zero_burst;
		wr_status && !HWDATA[TCSF_BIT_BURST] && !BURST_DONE;
	endsequence
	sequence seq_zero_conv;
		wr_status && !HWDATA[TCSF_BIT_CONV] && !CONV_DONE;
	endsequence

	chk_burst_set: assert property (
		BURST_DONE |=> burst_reg ##0 status_value[TCSF_BIT_BURST])
		else $error("burst flag not set after burst");
	chk_burst_clear: assert property (
		seq_zero_burst |=> !burst_reg)
		else $error("burst flag not cleared by zero write");
	chk_burst_rearm: assert property (
		!burst_reg && !BURST_DONE |=> !burst_reg)
		else $error("burst flag set without a burst");
	chk_conv_set: assert property (
		CONV_DONE |=> conv_reg)
		else $error("conversion flag not set");
	chk_conv_cycle: assert property (
		seq_zero_conv ##1 !CONV_DONE |=> !conv_reg)
		else $error("conversion flag came back early");
	chk_short_bit: assert property (
		status_value[TCSF_BIT_SHORT] == (FAULT_DETECT && SHORT_DETECT))
		else $error("short bit wrong");
	chk_emf_hold: assert property (
		CONV_DONE && EMF_OVER_RANGE |=> hot_reg == $past(hot_reg)
			&& diff_reg == $past(diff_reg)
			&& cold_reg == $past(CONV_COLD))
		else $error("result hold on EMF overrange wrong");
	chk_sum_hold: assert property (
		CONV_DONE && !EMF_OVER_RANGE && SUM_OVER_RANGE
			|=> hot_reg == $past(hot_reg)
			&& diff_reg == $past(CONV_DIFF)
			&& range_bit)
		else $error("result hold on sum overrange wrong");
	chk_range_clear: assert property (
		CONV_DONE && !EMF_OVER_RANGE && !SUM_OVER_RANGE && !OPEN_DETECT
			##1 !CONV_DONE && !OPEN_DETECT |-> !range_bit)
		else $error("range bit set while in range");
	chk_open_range: assert property (
		FAULT_DETECT && OPEN_DETECT |-> status_value[TCSF_BIT_RANGE])
		else $error("open input not shown as range fault");
	chk_alert_zero: assert property (
		!alert_src_reg[0] && $signed(hot_reg) <= $signed(limit_reg[0])
			|-> !ALERT_STATE[0])
		else $error("alert set at or below limit");

endmodule // tcsf_status

/* File: tb/tcsf_host.sv */
// Bus master model standing in for the host software
`timescale 1ns/1ns
module tcsf_host (
	// Clock
	input wire logic CLOCK,
	// Master outputs
	output logic HSEL,
	output logic [31:0] HADDR,
	output logic [1:0] HTRANS,
	output logic HWRITE,
	output logic [2:0] HSIZE,
	output logic [31:0] HWDATA,
	output logic hang,
	// Slave answer
	input wire logic HREADY,
	input wire logic [31:0] HRDATA
);
	// Idle bus until the first transfer
	initial begin
		HSEL = 1'b0;
		HADDR = 32'h00000000;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h00000000;
		hang = 1'b0;
	end
	// Bounded wait; a stuck slave is flagged, never waited on forever
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge CLOCK);
			k++;
		end while (HREADY !== 1'b1 && k < 64);
		if (HREADY !== 1'b1)
			hang <= 1'b1;
	endtask
	// Single word transfer; clearing writes carry zero bits
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h000000, a};
		HWRITE <= w;
		wait_rdy();
		// Select only matters in the address phase
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		wait_rdy();
		rd = HRDATA;
	endtask
endmodule // tcsf_host

/* File: tb/tcsf_status_tb_top.sv */
// Self-checking bench for the thermocouple status flag block
`timescale 1ns/1ns
module tcsf_status_tb_top;
	import tcsf_pkg::*;
	// Design pins
	logic clock, rst, hsel, hwrite, hreadyout, irq, hang, conv_done;
	logic burst_done, emf_over, sum_over, short_detect, open_detect;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize;
	logic [15:0] h, d, c, ehot, ediff, ecold;
	logic [15:0] elim [4];
	logic [3:0] alert_state;
	logic [3:0] esrc; // Expected alert source select
	logic [31:0] plain_rd; // Read data of the variant without fault sense
	// Expected flag state
	logic eb, ec, er;
	int n_mismatch, comparisons;
	tcsf_status #(.FAULT_DETECT(1'b1), .NUM_ALERTS(4)) u_dut (
		.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .CONV_DONE(conv_done), .BURST_DONE(burst_done),
		.CONV_HOT(h), .CONV_DIFF(d), .CONV_COLD(c),
		.EMF_OVER_RANGE(emf_over), .SUM_OVER_RANGE(sum_over),
		.SHORT_DETECT(short_detect), .OPEN_DETECT(open_detect),
		.IRQ(irq), .ALERT_STATE(alert_state));
	tcsf_host u_host (.CLOCK(clock), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.hang(hang), .HREADY(hreadyout), .HRDATA(hrdata));
	// Variant without fault sense on the same bus; only its read data used
	tcsf_status #(.FAULT_DETECT(1'b0), .NUM_ALERTS(4)) u_dut_plain (
		.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(plain_rd), .HREADYOUT(),
		.HRESP(), .CONV_DONE(conv_done), .BURST_DONE(burst_done),
		.CONV_HOT(h), .CONV_DIFF(d), .CONV_COLD(c),
		.EMF_OVER_RANGE(emf_over), .SUM_OVER_RANGE(sum_over),
		.SHORT_DETECT(short_detect), .OPEN_DETECT(open_detect),
		.IRQ(), .ALERT_STATE());
	// Clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// A stuck bus ends the run as a mismatch
	always @(posedge hang) begin
		n_mismatch++;
		tally_and_finish();
	end
	// Expected status word from the tracked flags
	function automatic logic [31:0] exp_stat();
		logic [3:0] al;
		for (int i = 0; i < 4; i++)
			al[i] = $signed(esrc[i] ? ecold : ehot)
				> $signed(elim[i]);
		return {24'h000000, eb, ec, short_detect, er | open_detect, al};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		u_host.xfer(1'b1, a, v, rd);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h00000000, rd);
		chk(nm, e, rd);
	endtask
	// Pins sampled mid-cycle where they are settled
	task automatic chk_pins(input logic ei);
		logic [31:0] e;
		@(negedge clock);
		e = exp_stat();
		chk("alert", {28'h0000000, e[3:0]}, {28'h0000000, alert_state});
		chk("irq", {31'h00000000, ei}, {31'h00000000, irq});
		@(posedge clock);
	endtask
	task automatic chk_stat();
		rdc("status", TCSF_ADDR_STATUS, exp_stat());
		chk_pins(1'b0);
	endtask
	// One conversion pulse; hold rules decide the expected results
	task automatic conv(input logic emf, input logic sum);
		@(posedge clock);
		conv_done <= 1'b1;
		emf_over <= emf;
		sum_over <= sum;
		ec = 1'b1;
		er = emf | sum;
		ecold = c;
		if (!emf)
			ediff = d;
		if (!emf && !sum)
			ehot = h;
		@(posedge clock);
		conv_done <= 1'b0;
	endtask
	task automatic burst();
		@(posedge clock);
		burst_done <= 1'b1;
		eb = 1'b1;
		@(posedge clock);
		burst_done <= 1'b0;
	endtask
	// Main sequence
	initial begin
		{rst, conv_done, burst_done, emf_over, sum_over} = 5'h10;
		{short_detect, open_detect, eb, ec, er} = 5'h00;
		{h, d, c, ehot, ediff, ecold} = 96'h0;
		elim = '{4{16'h0000}};
		esrc = 4'h0;
		n_mismatch = 0;
		comparisons = 0;
		void'($urandom(32'h6c31e115));
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk_stat();
		chk("resp", 32'h00000000, {30'h00000000, hresp});
		rdc("unmapped", 8'h80, 32'h00000000);
		// Random results, cycling through the range cases
		for (int i = 0; i < 9; i++) begin
			{h, d} <= $urandom;
			c <= 16'($urandom);
			conv(i % 3 == 1, i % 3 == 2);
			chk_stat();
			rdc("hot", TCSF_ADDR_HOT, {16'h0000, ehot});
			rdc("diff", TCSF_ADDR_DIFF, {16'h0000, ediff});
			rdc("cold", TCSF_ADDR_COLD, {16'h0000, ecold});
		end
		wr(TCSF_ADDR_STATUS, 32'h000000BF);
		ec = 1'b0;
		chk_stat();
		conv(1'b0, 1'b0);
		chk_stat();
		burst();
		chk_stat();
		wr(TCSF_ADDR_STATUS, 32'h0000007F);
		eb = 1'b0;
		chk_stat();
		burst();
		chk_stat();
		// Zero write clears both flags but not the live fault bits
		short_detect <= 1'b1;
		open_detect <= 1'b1;
		wr(TCSF_ADDR_STATUS, 32'h00000000);
		{eb, ec} = 2'h0;
		chk_stat();
		// Plain variant: short bit zero, range bit only from the results
		chk("plain_status", exp_stat() & ~32'h00000030 | {27'h0, er, 4'h0},
			plain_rd);
		short_detect <= 1'b0;
		open_detect <= 1'b0;
		// Negative result against limits equal to and just below it
		h <= 16'hFF38;
		conv(1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			elim[i] = ehot - 16'(i);
			wr(TCSF_ADDR_LIMIT0 + 8'(4 * i), {16'h0000, elim[i]});
		end
		chk_stat();
		// Interrupt: mask, clear by read, raise, clear again
		wr(TCSF_ADDR_IRQ_MASK, 32'h00000040);
		u_host.xfer(1'b0, TCSF_ADDR_IRQ_STATUS, 32'h00000000, rd);
		chk_pins(1'b0);
		conv(1'b0, 1'b0);
		chk_pins(1'b1);
		u_host.xfer(1'b0, TCSF_ADDR_IRQ_STATUS, 32'h00000000, rd);
		chk("irq_status", 32'h00000040, rd & 32'h000000C0);
		chk_pins(1'b0);
		// Alert source select: alerts 0 and 2 follow the cold junction
		wr(TCSF_ADDR_ALERT_SRC, 32'h00000005);
		esrc = 4'h5;
		rdc("src", TCSF_ADDR_ALERT_SRC, 32'h00000005);
		chk_stat();
		tally_and_finish();
	end
endmodule // tcsf_status_tb_top
